// ===== hdl/spfs_pkg.sv
`default_nettype none
package spfs_pkg;
   // reference clock and reset-delay timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
   localparam int unsigned POR_DELAY_MS = 200;
   localparam int unsigned POR_DELAY_CYC = POR_DELAY_MS * CLK_PER_MS;
   // watchdog periods, plain defaults
   localparam int unsigned WD_SHORT_MS = 200;
   localparam int unsigned WD_MID_MS = 600;
   localparam int unsigned WD_LONG_MS = 1400;
   localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * CLK_PER_MS;
   localparam int unsigned WD_MID_CYC = WD_MID_MS * CLK_PER_MS;
   localparam int unsigned WD_LONG_CYC = WD_LONG_MS * CLK_PER_MS;
   // serial framing
   localparam int unsigned BYTE_W = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] BIT_ONE = 3'h1;
   // synchroniser lanes
   localparam int unsigned SYNC_W = 4;
   localparam int unsigned SY_CS = 0;
   localparam int unsigned SY_WP = 1;
   localparam int unsigned SY_SUP = 2;
   localparam int unsigned SY_TOG = 3;
   localparam logic [SYNC_W-1:0] SYNC_RST = 4'h3;
   localparam logic [31:0] CNT_ONE = 32'h0000_0001;
   localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {
      SPFS_WD_LONG = 2'h0,
      SPFS_WD_MID = 2'h1,
      SPFS_WD_SHORT = 2'h2,
      SPFS_WD_OFF = 2'h3
   } spfs_wd_sel_t;
   typedef enum logic [1:0] {
      SPFS_RS_HOLD = 2'h1,
      SPFS_RS_RUN = 2'h2
   } spfs_rs_state_t;
endpackage : spfs_pkg
`default_nettype wire

// ===== hdl/spfs_sync2.sv
`default_nettype none
module spfs_sync2 #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q_ff
);
   logic [W-1:0] meta_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= RST_VAL;
         q_ff <= RST_VAL;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end
endmodule : spfs_sync2
`default_nettype wire

// ===== hdl/spfs_link_shift.sv
`default_nettype none
module spfs_link_shift (
   input wire logic sck,
   input wire logic cs_n,
   input wire logic link_clr,
   input wire logic si,
   input wire logic [7:0] tx_byte,
   output logic so_ff,
   output logic [7:0] rx_byte_ff,
   output logic rx_tog_ff
);
   logic [2:0] rx_cnt_ff;
   logic [6:0] rx_sh_ff;
   logic [2:0] tx_cnt_ff;
   logic [6:0] tx_sh_ff;

   // deselect clears the frame state, sck may be stopped then
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         rx_cnt_ff <= 3'h0;
         rx_sh_ff <= 7'h00;
      end else begin
         rx_sh_ff <= {rx_sh_ff[5:0], si};
         rx_cnt_ff <= 3'(rx_cnt_ff + spfs_pkg::BIT_ONE);
      end
   end

   // byte and toggle survive deselect so the core side sees the event
   always_ff @(posedge sck or posedge link_clr) begin
      if (link_clr) begin
         rx_byte_ff <= 8'h00;
         rx_tog_ff <= 1'b0;
      end else if (!cs_n && rx_cnt_ff == spfs_pkg::LAST_BIT) begin
         rx_byte_ff <= {rx_sh_ff, si};
         rx_tog_ff <= ~rx_tog_ff;
      end
   end

   // output changes on falling edges, new byte after each eighth bit
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         tx_cnt_ff <= 3'h0;
         tx_sh_ff <= 7'h00;
         so_ff <= 1'b0;
      end else begin
         tx_cnt_ff <= 3'(tx_cnt_ff + spfs_pkg::BIT_ONE);
         if (tx_cnt_ff == spfs_pkg::LAST_BIT) begin
            {so_ff, tx_sh_ff} <= tx_byte;
         end else begin
            {so_ff, tx_sh_ff} <= {tx_sh_ff, 1'b0};
         end
      end
   end
endmodule : spfs_link_shift
`default_nettype wire

// ===== hdl/spfs_top.sv
`default_nettype none
module spfs_top #(
   parameter int unsigned POR_CYC = spfs_pkg::POR_DELAY_CYC,
   parameter int unsigned WD_SHORT_CYC = spfs_pkg::WD_SHORT_CYC,
   parameter int unsigned WD_MID_CYC = spfs_pkg::WD_MID_CYC,
   parameter int unsigned WD_LONG_CYC = spfs_pkg::WD_LONG_CYC,
   parameter bit RST_ACTIVE_HIGH = 1'b0
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic sck,
   input wire logic select_and_kick_pin_n,
   input wire logic si,
   output logic so_o,
   output logic so_oe,
   input wire logic wp_n,
   input wire logic supply_ok,
   output logic rst_pin_o,
   output logic rst_pin_oe,
   input wire logic [1:0] wd_period_sel,
   input wire logic read_drive,
   input wire logic tx_load,
   input wire logic [7:0] tx_data,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic wr_commit,
   input wire logic write_cycle_busy,
   output logic nv_write_go,
   output logic write_blocked,
   output logic active_mode,
   output logic standby_mode,
   output logic select_armed
);
   localparam logic RST_LVL = RST_ACTIVE_HIGH;

   logic [spfs_pkg::SYNC_W-1:0] sync_q;
   logic cs_s;
   logic wp_s;
   logic supply_s;
   logic tog_s;
   logic cs_prev_ff;
   logic wp_prev_ff;
   logic tog_prev_ff;
   logic cs_fall;
   logic wp_fall;
   logic tog_evt;
   logic link_clr_ff;
   logic [7:0] tx_hold_ff;
   logic [7:0] link_rx_byte;
   logic link_rx_tog;
   logic armed_ff;
   logic rx_valid_ff;
   logic [7:0] rx_data_ff;
   logic abort_ff;
   logic nv_write_go_ff;
   logic write_blocked_ff;
   logic active_ff;
   logic standby_ff;
   logic so_oe_ff;
   logic [31:0] wd_cnt_ff;
   logic [31:0] wd_lim;
   logic wd_on;
   logic wd_to;
   logic [31:0] rs_cnt_ff;
   spfs_pkg::spfs_rs_state_t rs_state_ff;
   spfs_pkg::spfs_rs_state_t nxt_rs_state;
   logic rst_oe_ff;
   logic rst_o_ff;

   // pins and the link toggle cross into ref_clk here
   spfs_sync2 #(
      .W(spfs_pkg::SYNC_W),
      .RST_VAL(spfs_pkg::SYNC_RST)
   ) u_sync (
      .clk(ref_clk),
      .rst(sys_rst),
      .d({link_rx_tog, supply_ok, wp_n, select_and_kick_pin_n}),
      .q_ff(sync_q)
   );

   assign cs_s = sync_q[spfs_pkg::SY_CS];
   assign wp_s = sync_q[spfs_pkg::SY_WP];
   assign supply_s = sync_q[spfs_pkg::SY_SUP];
   assign tog_s = sync_q[spfs_pkg::SY_TOG];

   spfs_link_shift u_link (
      .sck(sck),
      .cs_n(select_and_kick_pin_n),
      .link_clr(link_clr_ff),
      .si(si),
      .tx_byte(tx_hold_ff),
      .so_ff(so_o),
      .rx_byte_ff(link_rx_byte),
      .rx_tog_ff(link_rx_tog)
   );

   // edge history on synchronised levels
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cs_prev_ff <= 1'b1;
         wp_prev_ff <= 1'b1;
         tog_prev_ff <= 1'b0;
         link_clr_ff <= 1'b1;
      end else begin
         cs_prev_ff <= cs_s;
         wp_prev_ff <= wp_s;
         tog_prev_ff <= tog_s;
         link_clr_ff <= 1'b0;
      end
   end

   assign cs_fall = cs_prev_ff && !cs_s;
   assign wp_fall = wp_prev_ff && !wp_s;
   assign tog_evt = tog_prev_ff != tog_s;

   // held quasi-static: the link loads it on a byte boundary
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_hold_ff <= 8'h00;
      end else if (tx_load) begin
         tx_hold_ff <= tx_data;
      end
   end

   // nothing is accepted until a select fall has been seen
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         armed_ff <= 1'b0;
      end else if (cs_fall) begin
         armed_ff <= 1'b1;
      end
   end

   // link byte is stable for eight sck periods after its toggle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rx_valid_ff <= 1'b0;
         rx_data_ff <= 8'h00;
      end else begin
         rx_valid_ff <= tog_evt && armed_ff;
         if (tog_evt && armed_ff) begin
            rx_data_ff <= link_rx_byte;
         end
      end
   end

   // abort set wins over the clear at the next frame start
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         abort_ff <= 1'b0;
      end else if (wp_fall && !cs_s) begin
         abort_ff <= 1'b1;
      end else if (cs_fall) begin
         abort_ff <= 1'b0;
      end
   end

   // only the start is gated; a running cycle is never cancelled
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         nv_write_go_ff <= 1'b0;
         write_blocked_ff <= 1'b1;
      end else begin
         nv_write_go_ff <= wr_commit && wp_s && !abort_ff && armed_ff;
         write_blocked_ff <= !wp_s || abort_ff;
      end
   end

   // power mode and output driver
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         active_ff <= 1'b0;
         standby_ff <= 1'b1;
         so_oe_ff <= 1'b0;
      end else begin
         active_ff <= !cs_s;
         standby_ff <= cs_s && !write_cycle_busy && !nv_write_go_ff;
         so_oe_ff <= !cs_s && armed_ff && read_drive;
      end
   end

   // watchdog period from the stored select bits
   always_comb begin
      wd_on = 1'b1;
      case (spfs_pkg::spfs_wd_sel_t'(wd_period_sel))
         spfs_pkg::SPFS_WD_LONG: wd_lim = WD_LONG_CYC;
         spfs_pkg::SPFS_WD_MID: wd_lim = WD_MID_CYC;
         spfs_pkg::SPFS_WD_SHORT: wd_lim = WD_SHORT_CYC;
         default: begin
            wd_lim = spfs_pkg::CNT_ZERO;
            wd_on = 1'b0;
         end
      endcase
   end

   assign wd_to = wd_on && (wd_cnt_ff >= wd_lim);

   // counts while select holds its level either way
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wd_cnt_ff <= spfs_pkg::CNT_ZERO;
      end else if (cs_fall || !wd_on || rs_state_ff == spfs_pkg::SPFS_RS_HOLD) begin
         wd_cnt_ff <= spfs_pkg::CNT_ZERO;
      end else begin
         wd_cnt_ff <= wd_cnt_ff + spfs_pkg::CNT_ONE;
      end
   end

   // reset supervisor: hold until supply good for the full delay
   always_comb begin
      nxt_rs_state = rs_state_ff;
      case (rs_state_ff)
         spfs_pkg::SPFS_RS_HOLD: begin
            if (supply_s && rs_cnt_ff >= POR_CYC - 1) begin
               nxt_rs_state = spfs_pkg::SPFS_RS_RUN;
            end
         end
         spfs_pkg::SPFS_RS_RUN: begin
            if (!supply_s || wd_to) begin
               nxt_rs_state = spfs_pkg::SPFS_RS_HOLD;
            end
         end
         default: nxt_rs_state = spfs_pkg::SPFS_RS_HOLD;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rs_state_ff <= spfs_pkg::SPFS_RS_HOLD;
      end else begin
         rs_state_ff <= nxt_rs_state;
      end
   end

   // any dip restarts the whole delay, not a resume
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rs_cnt_ff <= spfs_pkg::CNT_ZERO;
      end else if (!supply_s || rs_state_ff != spfs_pkg::SPFS_RS_HOLD) begin
         rs_cnt_ff <= spfs_pkg::CNT_ZERO;
      end else begin
         rs_cnt_ff <= rs_cnt_ff + spfs_pkg::CNT_ONE;
      end
   end

   // open drain: the level is fixed, only the enable moves
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rst_oe_ff <= 1'b1;
         rst_o_ff <= RST_LVL;
      end else begin
         rst_oe_ff <= rs_state_ff == spfs_pkg::SPFS_RS_HOLD;
         rst_o_ff <= RST_LVL;
      end
   end

   assign rx_valid = rx_valid_ff;
   assign rx_data = rx_data_ff;
   assign nv_write_go = nv_write_go_ff;
   assign write_blocked = write_blocked_ff;
   assign active_mode = active_ff;
   assign standby_mode = standby_ff;
   assign select_armed = armed_ff;
   assign so_oe = so_oe_ff;
   assign rst_pin_oe = rst_oe_ff;
   assign rst_pin_o = rst_o_ff;

   sequence sel_fall_s;
      cs_prev_ff && !cs_s;
   endsequence

   sequence wp_drop_in_frame_s;
      wp_prev_ff && !wp_s && !cs_s;
   endsequence

   sequence supply_lost_s;
      !supply_s;
   endsequence

   so_float_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cs_s |=> !so_oe) else $error("serial output driven while deselected");

   standby_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cs_s && !write_cycle_busy && !nv_write_go) |=> (standby_mode && !active_mode))
      else $error("standby not entered while deselected and idle");

   arm_first_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !select_armed |=> !rx_valid && !nv_write_go)
      else $error("activity before first select fall");

   arm_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_fall_s |=> select_armed) else $error("select fall did not arm");

   wp_block_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !wp_s |=> !nv_write_go ##0 write_blocked)
      else $error("write started with protect low");

   wp_pass_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (wr_commit && wp_s && !abort_ff && select_armed) |=> nv_write_go)
      else $error("permitted write not started");

   wp_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wp_drop_in_frame_s ##1 (wr_commit && !cs_fall) |=> !nv_write_go)
      else $error("aborted write still started");

   go_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (write_cycle_busy || nv_write_go) |=> !standby_mode)
      else $error("started write dropped into standby");

   rst_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rst_pin_oe |-> rst_pin_o == RST_LVL)
      else $error("reset driven at wrong level");

   uv_reset_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      supply_lost_s |=> ##1 rst_pin_oe) else $error("undervoltage without reset");

   uv_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      supply_lost_s ##1 (supply_s && POR_CYC > 8) |=> rst_pin_oe [*8])
      else $error("reset released too early after supply return");

   wd_fire_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (rs_state_ff == spfs_pkg::SPFS_RS_RUN && wd_to) |=> ##1 rst_pin_oe)
      else $error("watchdog timeout without reset");

   wd_kick_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_fall_s |=> wd_cnt_ff == spfs_pkg::CNT_ZERO)
      else $error("select fall did not restart watchdog");

   wd_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (wd_period_sel == spfs_pkg::SPFS_WD_OFF) |-> !wd_to)
      else $error("watchdog fired while disabled");
endmodule : spfs_top
`default_nettype wire

// ===== sim/spfs_spi_master.sv
`default_nettype none
module spfs_spi_master (
   output logic sck,
   output logic select_and_kick_pin_n,
   output logic si,
   input wire logic so_o,
   input wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam time HALF = 16ns;
   logic so_wire;
   // a floating output must never read back as data
   assign so_wire = so_oe ? so_o : 1'hz;
   initial begin
      sck = 1'h0;
      select_and_kick_pin_n = 1'h1;
      si = 1'h0;
   end
   task automatic sel(input logic lvl);
      select_and_kick_pin_n = lvl;
   endtask : sel
   // two bytes in one selection, clock idles low between frames
   task automatic frame2(input logic [15:0] mosi, output logic [15:0] miso);
      sel(1'h0);
      #(2 * HALF);
      for (int i = 15; i >= 0; i--) begin
         si = mosi[i];
         #HALF sck = ~sck;
         miso[i] = so_wire;
         #HALF sck = ~sck;
      end
      #HALF;
      sel(1'h1);
      si = ~si;
   endtask : frame2
endmodule : spfs_spi_master
`default_nettype wire

// ===== sim/serial_pin_front_end_supervisor_bench.sv
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module serial_pin_front_end_supervisor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int POR_CYC = 50;
   logic ref_clk, sys_rst, sck, cs_n, si, so_o, so_oe, wp_n, supply_ok;
   logic rst_pin_o, rst_pin_oe, read_drive, tx_load, rx_valid, wr_commit;
   logic write_cycle_busy, nv_write_go, write_blocked, active_mode, standby_mode;
   logic select_armed;
   logic [1:0] wd_period_sel;
   logic [7:0] tx_data, rx_data;
   logic [7:0] n_rx = 8'h00;
   int num_errors = 0;
   int n_checks = 0;
   spfs_top #(.POR_CYC(POR_CYC), .WD_SHORT_CYC(100), .WD_MID_CYC(200),
      .WD_LONG_CYC(300)) spfs_top_inst (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .sck(sck),
      .select_and_kick_pin_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe),
      .wp_n(wp_n), .supply_ok(supply_ok), .rst_pin_o(rst_pin_o),
      .rst_pin_oe(rst_pin_oe), .wd_period_sel(wd_period_sel),
      .read_drive(read_drive), .tx_load(tx_load), .tx_data(tx_data),
      .rx_data(rx_data), .rx_valid(rx_valid), .wr_commit(wr_commit),
      .write_cycle_busy(write_cycle_busy), .nv_write_go(nv_write_go),
      .write_blocked(write_blocked), .active_mode(active_mode),
      .standby_mode(standby_mode), .select_armed(select_armed));
   spfs_spi_master spfs_spi_master_inst (.sck(sck), .select_and_kick_pin_n(cs_n),
      .si(si), .so_o(so_o), .so_oe(so_oe));
   initial begin
      ref_clk = 1'h0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (rx_valid === 1'h1) n_rx <= n_rx + 8'h01;
   function automatic int wd_cyc(input int s);
      return (s == 0) ? 300 : (s == 1) ? 200 : 100;
   endfunction : wd_cyc
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic wait_rst(input logic lvl, input int lim);
      int k;
      k = 0;
      while (rst_pin_oe !== lvl && k < lim) begin
         cyc(1);
         k++;
      end
      `CHK("rst_pin_oe", lvl, rst_pin_oe)
      if (rst_pin_oe !== lvl) complete_run();
   endtask : wait_rst
   task automatic commit(input logic exp);
      logic seen;
      seen = 1'h0;
      wr_commit = 1'h1;
      cyc(1);
      wr_commit = 1'h0;
      repeat (2) begin
         seen = seen | nv_write_go;
         cyc(1);
      end
      `CHK("nv_write_go", exp, seen)
   endtask : commit
   task automatic kick();
      spfs_spi_master_inst.sel(1'h0);
      cyc(4);
      spfs_spi_master_inst.sel(1'h1);
   endtask : kick
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      complete_run();
   end
   initial begin
      logic [15:0] mosi, miso;
      logic [7:0] txb;
      sys_rst = 1'h1;
      void'($urandom(32'h950D));
      // inputs wander during reset, outputs must not follow
      repeat (20) begin
         {wp_n, supply_ok, read_drive, tx_load, wr_commit, write_cycle_busy} = 6'($urandom);
         wd_period_sel = 2'($urandom);
         tx_data = 8'($urandom);
         cyc(1);
      end
      `CHK("so_oe", 1'h0, so_oe)
      `CHK("rst_pin_oe", 1'h1, rst_pin_oe)
      `CHK("rst_pin_o", 1'h0, rst_pin_o)
      `CHK("standby_mode", 1'h1, standby_mode)
      `CHK("select_armed", 1'h0, select_armed)
      wp_n = 1'h1;
      supply_ok = 1'h1;
      wd_period_sel = 2'h3;
      read_drive = 1'h0;
      tx_load = 1'h0;
      tx_data = 8'h00;
      wr_commit = 1'h0;
      write_cycle_busy = 1'h0;
      sys_rst = 1'h0;
      cyc(POR_CYC - 10);
      `CHK("rst_pin_oe", 1'h1, rst_pin_oe)
      wait_rst(1'h0, 30);
      commit(1'h0);
      spfs_spi_master_inst.sel(1'h0);
      cyc(5);
      `CHK("active_mode", 1'h1, active_mode)
      `CHK("standby_mode", 1'h0, standby_mode)
      `CHK("select_armed", 1'h1, select_armed)
      spfs_spi_master_inst.sel(1'h1);
      read_drive = 1'h1;
      for (int f = 0; f < 5; f++) begin
         mosi = (f == 0) ? 16'h0180 : 16'($urandom);
         txb = (f == 0) ? 8'h81 : 8'($urandom);
         tx_data = txb;
         tx_load = 1'h1;
         cyc(1);
         tx_load = 1'h0;
         spfs_spi_master_inst.frame2(mosi, miso);
         cyc(6);
         `CHK("rx_data", mosi[7:0], rx_data)
         `CHK("so_byte", txb, miso[7:0])
         `CHK("so_oe", 1'h0, so_oe)
         `CHK("standby_mode", 1'h1, standby_mode)
      end
      `CHK("rx_count", 8'h0A, n_rx)
      commit(1'h1);
      wp_n = 1'h0;
      cyc(5);
      `CHK("write_blocked", 1'h1, write_blocked)
      commit(1'h0);
      wp_n = 1'h1;
      cyc(5);
      `CHK("write_blocked", 1'h0, write_blocked)
      spfs_spi_master_inst.sel(1'h0);
      cyc(4);
      wp_n = 1'h0;
      cyc(3);
      commit(1'h0);
      wp_n = 1'h1;
      cyc(5);
      commit(1'h0);
      `CHK("write_blocked", 1'h1, write_blocked)
      spfs_spi_master_inst.sel(1'h1);
      cyc(4);
      kick();
      cyc(4);
      spfs_spi_master_inst.sel(1'h0);
      cyc(5);
      commit(1'h1);
      spfs_spi_master_inst.sel(1'h1);
      write_cycle_busy = 1'h1;
      wp_n = 1'($urandom);
      cyc(4);
      `CHK("standby_mode", 1'h0, standby_mode)
      write_cycle_busy = 1'h0;
      wp_n = 1'h1;
      supply_ok = 1'h0;
      wait_rst(1'h1, 8);
      cyc(20);
      supply_ok = 1'h1;
      cyc(POR_CYC - 10);
      `CHK("rst_pin_oe", 1'h1, rst_pin_oe)
      wait_rst(1'h0, 20);
      for (int s = 0; s < 3; s++) begin
         wd_period_sel = 2'(s);
         kick();
         cyc(wd_cyc(s) - 15);
         `CHK("rst_pin_oe", 1'h0, rst_pin_oe)
         wait_rst(1'h1, 30);
         wd_period_sel = 2'h3;
         wait_rst(1'h0, POR_CYC + 30);
      end
      // select stuck low must time out as well
      wd_period_sel = 2'h2;
      spfs_spi_master_inst.sel(1'h0);
      cyc(85);
      `CHK("rst_pin_oe", 1'h0, rst_pin_oe)
      wait_rst(1'h1, 30);
      spfs_spi_master_inst.sel(1'h1);
      wd_period_sel = 2'h3;
      wait_rst(1'h0, POR_CYC + 30);
      wd_period_sel = 2'h2;
      for (int k = 0; k < 5; k++) begin
         kick();
         cyc(60);
         `CHK("rst_pin_oe", 1'h0, rst_pin_oe)
      end
      wd_period_sel = 2'h3;
      cyc(400);
      `CHK("rst_pin_oe", 1'h0, rst_pin_oe)
      complete_run();
   end
endmodule : serial_pin_front_end_supervisor_bench
`default_nettype wire
